// file: hw/port_pin_cell_config.sv
`timescale 1ns/10ps
`default_nettype none

module port_pin_cell_config
  import port_cfg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // per-port configuration writes
  input wire logic [NUM_PORTS-1:0] cfg_wr,
  input wire logic [7:0] pin_input_mode_select_wdata,
  input wire logic [7:0] pin_output_type_select_wdata,
  input wire logic [7:0] pin_drive_strength_select_wdata,
  input wire logic [7:0] crossbar_pin_skip_wdata,
  input wire logic [7:0] latch_wdata,
  // route select writes
  input wire logic route_wr_0,
  input wire logic route_wr_1,
  input wire logic [7:0] peripheral_route_select_0_wdata,
  input wire logic [7:0] peripheral_route_select_1_wdata,
  // crossbar connection, one bit per pin, plus route select and both flag bits read back
  input wire logic [NUM_PINS-1:0] xbar_sel,
  input wire logic [NUM_PINS-1:0] xbar_out,
  input wire logic [NUM_PINS-1:0] xbar_oe,
  output logic [NUM_PINS-1:0] crossbar_pin_skip,
  output logic [7:0] peripheral_route_select_0,
  output logic [7:0] peripheral_route_select_1,
  output logic crossbar_enable_bit,
  output logic global_pullup_disable,
  // pads
  input wire logic [NUM_PINS-1:0] pad_in,
  output logic [NUM_PINS-1:0] pad_out,
  output logic [NUM_PINS-1:0] pad_oe,
  output logic [NUM_PINS-1:0] pad_pullup_en,
  output logic [NUM_PINS-1:0] pad_high_drive,
  output logic [NUM_PINS-1:0] pad_rx_en,
  // read back
  output logic [NUM_PINS-1:0] pin_read,
  output logic [NUM_PINS-1:0] pin_input_mode_select,
  output logic [NUM_PINS-1:0] pin_output_type_select,
  output logic [NUM_PINS-1:0] pin_drive_strength_select,
  output logic [NUM_PINS-1:0] latch_value
);

  logic [NUM_PINS-1:0] mdin_q;
  logic [NUM_PINS-1:0] mdout_q;
  logic [NUM_PINS-1:0] drv_q;
  logic [NUM_PINS-1:0] skip_q;
  logic [NUM_PINS-1:0] latch_q;
  logic [7:0] route0_q;
  logic [7:0] route1_q;
  logic [NUM_PINS-1:0] sync1_q;
  logic [NUM_PINS-1:0] sync2_q;
  logic [NUM_PINS-1:0] read_q;
  logic [NUM_PINS-1:0] mdin_d;
  logic [NUM_PINS-1:0] out_val;
  logic [NUM_PINS-1:0] drive_lo;
  logic [NUM_PINS-1:0] drive_hi;

  // per-port settings, one bit per pin
  generate
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          mdin_q[p*PIN_COUNT +: PIN_COUNT] <= INPUT_MODE_RST;
          mdout_q[p*PIN_COUNT +: PIN_COUNT] <= OUTPUT_TYPE_RST;
          drv_q[p*PIN_COUNT +: PIN_COUNT] <= DRIVE_RST;
          skip_q[p*PIN_COUNT +: PIN_COUNT] <= SKIP_RST;
          latch_q[p*PIN_COUNT +: PIN_COUNT] <= LATCH_RST;
        end else if (cfg_wr[p]) begin
          mdin_q[p*PIN_COUNT +: PIN_COUNT] <= pin_input_mode_select_wdata;
          mdout_q[p*PIN_COUNT +: PIN_COUNT] <= pin_output_type_select_wdata;
          drv_q[p*PIN_COUNT +: PIN_COUNT] <= pin_drive_strength_select_wdata;
          skip_q[p*PIN_COUNT +: PIN_COUNT] <= crossbar_pin_skip_wdata;
          latch_q[p*PIN_COUNT +: PIN_COUNT] <= latch_wdata;
        end
      end
    end
  endgenerate

  // route select 1 carries the crossbar enable and pull-up disable bits
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      route0_q <= ROUTE_RST;
      route1_q <= ROUTE_RST;
    end else begin
      if (route_wr_0) begin
        route0_q <= peripheral_route_select_0_wdata;
      end
      if (route_wr_1) begin
        route1_q <= peripheral_route_select_1_wdata;
      end
    end
  end

  // pad synchroniser; first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
    end
  end

  // incoming mode, so the read gate switches in the same cycle as the mode itself
  always_comb begin
    mdin_d = mdin_q;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (cfg_wr[p]) begin
        mdin_d[p*PIN_COUNT +: PIN_COUNT] = pin_input_mode_select_wdata;
      end
    end
  end

  // read path: pad level for digital pins, zero for analog
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      read_q <= '0;
    end else begin
      read_q <= sync2_q & mdin_d;
    end
  end

  // output value: crossbar owns pins it selects and does not skip, once enabled, otherwise the latch
  always_comb begin
    out_val = latch_q;
    drive_lo = '0;
    drive_hi = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (route1_q[XBAR_EN_POS] && xbar_sel[i] && !skip_q[i]) begin
        out_val[i] = xbar_out[i] | ~xbar_oe[i];
      end
      // drivers stay off for analog pins and before crossbar enable
      if (mdin_q[i] && route1_q[XBAR_EN_POS]) begin
        drive_lo[i] = ~out_val[i];
        drive_hi[i] = out_val[i] & mdout_q[i];
      end
    end
  end

  // pad controls; pull-up only on floating digital pins
  assign pad_oe = drive_lo | drive_hi;
  assign pad_out = drive_hi;
  assign pad_pullup_en = mdin_q & ~drive_lo & ~drive_hi
                         & {NUM_PINS{~route1_q[PULLUP_DIS_POS]}};
  assign pad_high_drive = drv_q;
  assign pad_rx_en = mdin_q;

  // status outputs from registers
  assign pin_read = read_q;
  assign pin_input_mode_select = mdin_q;
  assign pin_output_type_select = mdout_q;
  assign pin_drive_strength_select = drv_q;
  assign crossbar_pin_skip = skip_q;
  assign latch_value = latch_q;
  assign peripheral_route_select_0 = route0_q;
  assign peripheral_route_select_1 = route1_q;
  assign crossbar_enable_bit = route1_q[XBAR_EN_POS];
  assign global_pullup_disable = route1_q[PULLUP_DIS_POS];

  AST_NO_DRIVE_BEFORE_XBAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !route1_q[XBAR_EN_POS] |-> pad_oe == '0)
    else $error("pad driven before crossbar enable");
  AST_ANALOG_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((pad_oe | pad_pullup_en | pad_rx_en) & ~mdin_q) == '0)
    else $error("analog pin has digital circuitry on");
  AST_ANALOG_READ_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pin_read & ~mdin_q) == '0)
    else $error("analog pin read nonzero");
  AST_OD_NEVER_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pad_out & ~mdout_q) == '0)
    else $error("open-drain pin driven high");
  AST_PUSHPULL_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((pad_oe ^ (mdin_q & mdout_q & {NUM_PINS{route1_q[XBAR_EN_POS]}}))
      & mdout_q & mdin_q) == '0)
    else $error("push-pull pin not driven");
  AST_GPIO_LEVEL: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((pad_out ^ latch_q) & mdin_q & mdout_q & ~(xbar_sel & ~skip_q)
      & {NUM_PINS{route1_q[XBAR_EN_POS]}}) == '0)
    else $error("push-pull pin level differs from latch");
  AST_OD_PULLS_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((~pad_oe | pad_out) & ~latch_q & mdin_q & ~mdout_q & ~(xbar_sel & ~skip_q)
      & {NUM_PINS{route1_q[XBAR_EN_POS]}}) == '0)
    else $error("open-drain pin not pulled low");
  AST_PULLUP_FLOATING: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !route1_q[PULLUP_DIS_POS] |-> pad_pullup_en == (mdin_q & ~pad_oe))
    else $error("pull-up wrong on floating or low pin");
  AST_GLOBAL_PULLUP_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    route1_q[PULLUP_DIS_POS] |-> pad_pullup_en == '0)
    else $error("pull-up on while globally disabled");
  AST_READ_IS_PAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    read_q == ($past(sync2_q) & mdin_q))
    else $error("read does not follow pad");
  AST_RESET_STATE: assert property (@(posedge ref_clk)
    !rst_n |=> pad_oe == '0 && pad_high_drive == '0 && pad_pullup_en == '1)
    else $error("bad state after reset");

endmodule : port_pin_cell_config

`default_nettype wire

// file: inc/port_cfg_pkg.sv
package port_cfg_pkg;
  // three crossbar ports of eight pins, P0.0 to P2.7
  localparam int NUM_PORTS = 3;
  localparam int PIN_COUNT = 8;
  localparam int NUM_PINS = NUM_PORTS * PIN_COUNT;
  // reset values: analog off means digital input, open-drain, low drive, nothing skipped
  localparam logic [7:0] INPUT_MODE_RST = 8'hFF;
  localparam logic [7:0] OUTPUT_TYPE_RST = 8'h00;
  localparam logic [7:0] DRIVE_RST = 8'h00;
  localparam logic [7:0] SKIP_RST = 8'h00;
  localparam logic [7:0] LATCH_RST = 8'hFF;
  localparam logic [7:0] ROUTE_RST = 8'h00;
  // field position of the crossbar enable bit inside route select 1
  localparam int XBAR_EN_POS = 6;
  // field position of the global pull-up disable bit inside route select 1
  localparam int PULLUP_DIS_POS = 7;
endpackage : port_cfg_pkg

// file: test/pad_partner.sv
`timescale 1ns/10ps
`default_nettype none
module pad_partner (
  // clock
  input wire logic ref_clk,
  // device side of the pads
  input wire logic [23:0] pad_out,
  input wire logic [23:0] pad_oe,
  input wire logic [23:0] pad_pullup_en,
  // outside drivers
  input wire logic [23:0] ext_en,
  input wire logic [23:0] ext_val,
  output logic [23:0] pad_in
);
  logic [23:0] wander_q = 24'h00_0000;
  // undriven pads without pull-up wander, so a stale level never passes for a valid one
  always @(posedge ref_clk) wander_q <= ~wander_q;
  // device drive wins over outside drive, pull-up only when nobody drives
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
    | (~pad_oe & ~ext_en & (pad_pullup_en | wander_q));
endmodule : pad_partner
`default_nettype wire

// file: test/port_pin_cell_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
module port_pin_cell_config_tb;
  import port_cfg_pkg::*;
  // stimulus
  logic ref_clk = 1'b0, rst_n = 1'b0, route_wr_0 = 1'b0, route_wr_1 = 1'b0;
  logic [2:0] cfg_wr = '0;
  logic [7:0] pin_input_mode_select_wdata = '0, pin_output_type_select_wdata = '0;
  logic [7:0] pin_drive_strength_select_wdata = '0, crossbar_pin_skip_wdata = '0;
  logic [7:0] latch_wdata = '0, peripheral_route_select_0_wdata = '0;
  logic [7:0] peripheral_route_select_1_wdata = '0;
  logic [23:0] xbar_sel = '0, xbar_out = '0, xbar_oe = '0, ext_en = '0, ext_val = '0;
  // design outputs
  logic [23:0] pad_in, pad_out, pad_oe, pad_pullup_en, pad_high_drive, pad_rx_en, pin_read;
  logic [23:0] crossbar_pin_skip, pin_input_mode_select, pin_output_type_select;
  logic [23:0] pin_drive_strength_select, latch_value;
  logic [7:0] peripheral_route_select_0, peripheral_route_select_1;
  logic crossbar_enable_bit, global_pullup_disable;
  // expectations
  logic [23:0] em, et, ed, es, el, e_oe, e_out, e_pu, known;
  int seed = 37074, err_count = 0, check_count = 0;
  always #20 ref_clk = ~ref_clk;
  port_pin_cell_config port_pin_cell_config_i (.*);
  pad_partner pad_partner_i (.*);
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic end_sim();
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // crossbar owns a pin only when enabled, selected and not skipped
  function automatic logic [2:0] pin_exp(input logic m, t, l, s, sel, xo, xoe, xen, pud);
    logic v;
    v = (xen & sel & ~s) ? (xo | ~xoe) : l;
    if (!xen || !m) return {2'b00, m & ~pud};
    return t ? {1'b1, v, 1'b0} : {~v, 1'b0, ~pud & v};
  endfunction : pin_exp
  task automatic check_all();
    logic [7:0] r1;
    r1 = peripheral_route_select_1_wdata;
    for (int i = 0; i < NUM_PINS; i++)
      {e_oe[i], e_out[i], e_pu[i]} = pin_exp(em[i], et[i], el[i], es[i], xbar_sel[i],
        xbar_out[i], xbar_oe[i], r1[XBAR_EN_POS], r1[PULLUP_DIS_POS]);
    // pull-up while driving high is left open, floating pads are not compared
    known = ~em | e_oe | ext_en | e_pu;
    chk("pad_oe", e_oe, pad_oe);
    chk("pad_out", e_out, pad_out);
    chk("pullup", e_pu, pad_pullup_en & ~(e_oe & e_out));
    chk("rx_en", em, pad_rx_en);
    chk("read", known & em & ((e_oe & e_out) | (~e_oe & (~ext_en | ext_val))),
      known & pin_read);
    chk("mode", em, pin_input_mode_select);
    chk("type", et, pin_output_type_select);
    chk("drive", ed, pin_drive_strength_select);
    chk("hdrive", ed, pad_high_drive);
    chk("skip", es, crossbar_pin_skip);
    chk("latch", el, latch_value);
    chk("route", {8'h00, peripheral_route_select_0_wdata, r1},
      {8'h00, peripheral_route_select_0, peripheral_route_select_1});
    chk("flags", {22'h0, r1[7:6]},
      {22'h0, global_pullup_disable, crossbar_enable_bit});
  endtask : check_all
  // modes, skips, routes, then the enable, each write back to back
  task automatic config_ports(input int k);
    logic [39:0] v;
    logic [7:0] r1;
    for (int p = 0; p < NUM_PORTS; p++) begin
      v = 40'({$random(seed), $random(seed)});
      if (k == 0) v[39:32] = 8'h00;
      if (k == 1) v[39:24] = 16'hFFFF;
      @(posedge ref_clk);
      cfg_wr <= 3'b001 << p;
      {pin_input_mode_select_wdata, pin_output_type_select_wdata,
        pin_drive_strength_select_wdata, crossbar_pin_skip_wdata, latch_wdata} <= v;
      {em[p*8+:8], et[p*8+:8], ed[p*8+:8], es[p*8+:8], el[p*8+:8]} = v;
    end
    r1 = 8'($random(seed));
    r1[6] = (k < 2) | (k > 2 && r1[6]);
    if (k == 1) r1[7] = 1'b1;
    @(posedge ref_clk);
    cfg_wr <= '0;
    route_wr_0 <= 1'b1;
    peripheral_route_select_0_wdata <= 8'($random(seed));
    @(posedge ref_clk);
    {route_wr_0, route_wr_1} <= 2'b01;
    peripheral_route_select_1_wdata <= r1;
    @(posedge ref_clk);
    route_wr_1 <= 1'b0;
    {xbar_sel, xbar_out} <= 48'({$random(seed), $random(seed)});
    {xbar_oe, ext_en, ext_val} <= 72'({$random(seed), $random(seed), $random(seed)});
    repeat (5) @(posedge ref_clk);
    #1;
    check_all();
  endtask : config_ports
  // reset for 4 cycles, then the reset state; route bytes cleared to match ROUTE_RST
  task automatic reset_check();
    rst_n <= 1'b0;
    {peripheral_route_select_0_wdata, peripheral_route_select_1_wdata} <= 16'h0000;
    {em, el} = {{3{INPUT_MODE_RST}}, {3{LATCH_RST}}};
    {et, ed, es} = {{3{OUTPUT_TYPE_RST}}, {3{DRIVE_RST}}, {3{SKIP_RST}}};
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    check_all();
  endtask : reset_check
  // reset state first, random setups with forced corners, then a reset at the end
  initial begin
    reset_check();
    for (int k = 0; k < 40; k++) config_ports(k);
    @(posedge ref_clk);
    reset_check();
    end_sim();
  end
endmodule : port_pin_cell_config_tb
`default_nettype wire
